// File: sim/etc8_pin_src.sv
// Behavioural source of events and pulses on the timer pin.
// Assumes the pin is sampled on clk; it changes after rising edges.
`timescale 1ns/1ps
`default_nettype none
module etc8_pin_src (
  input  wire  clk, // Logic clock
  output logic pin  // Timer input pin
);
  // ---------
  // Drivers
  // ---------
  initial pin = 1'b0;
  task automatic drive(input logic v, input int gap);
    @(posedge clk);
    pin <= v;
    repeat (gap) @(posedge clk);
  endtask
  // Gap sets how slowly the source changes
  task automatic toggle(input int n, input int gap);
    repeat (n) drive(!pin, gap);
  endtask
endmodule // etc8_pin_src
`default_nettype wire

// File: sim/etc8_timer_monitor.sv
// Assertions on the ports of the 8-bit timer/event counter.
// Assumes clk_en high around bus transfers and overflows; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "etc8_regs.vh"
module etc8_timer_monitor (
  input wire        clk,                   // Logic clock
  input wire        arst_n,                // Async reset
  input wire        psel,                  // APB select
  input wire        penable,               // APB enable
  input wire        pwrite,                // APB write
  input wire [7:0]  paddr,                 // APB address
  input wire [31:0] pwdata,                // APB write data
  input wire [31:0] prdata,                // APB read data
  input wire        overflow_pulse,        // Overflow request
  input wire [7:0]  pwm_duty_data,         // Duty byte
  input wire        pwm_resolution_select, // Resolution
  input wire        pwm_enable,            // PWM enable
  input wire [7:0]  counter_value          // Live counter
);
  // --------
  // Shadows
  // --------
  // Enable bit trusted in timer mode only: pulse mode clears it
  logic [7:0] ctl;
  logic [7:0] pre;
  wire        acc = psel && penable;
  wire        wr  = acc && pwrite;
  wire        pwm = ctl[7:6] == `ETC8_MODE_PWM;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= 8'h00;
      pre <= 8'h00;
    end else if (wr && paddr == `ETC8_OFS_CTRL) begin
      ctl <= pwdata[7:0] & 8'hdf;
    end else if (wr && paddr == `ETC8_OFS_COUNT && !pwm) begin
      pre <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_cnt;
    acc && !pwrite && paddr == `ETC8_OFS_COUNT && !pwm;
  endsequence
  sequence s_duty_wr;
    wr && paddr == `ETC8_OFS_COUNT && pwm;
  endsequence
  AST_OVF_ONE: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse too long");
  AST_OVF_FULL: assert property (
    overflow_pulse |-> $past(counter_value) == 8'hff)
    else $error("overflow without full count");
  AST_RELOAD: assert property (
    overflow_pulse |-> counter_value == pre)
    else $error("reload value wrong");
  AST_BIT5: assert property (
    acc && !pwrite && paddr == `ETC8_OFS_CTRL |-> prdata[5] == 1'b0)
    else $error("unused control bit read high");
  AST_HOLD: assert property (
    ctl[7:6] == `ETC8_MODE_TIMER && !ctl[4] && !wr |=> $stable(counter_value))
    else $error("stopped counter moved");
  AST_STEP: assert property (
    !pwm && !wr ##1 $changed(counter_value) |->
      counter_value == $past(counter_value) + 8'h01 ||
      $past(counter_value) == 8'hff)
    else $error("counter step not one");
  AST_PWM_CTL: assert property (
    pwm_enable == (pwm && ctl[0]) && pwm_resolution_select == ctl[1])
    else $error("pwm control outputs wrong");
  AST_DUTY: assert property (
    s_duty_wr |=> pwm_duty_data == $past(pwdata[7:0]))
    else $error("duty byte not written");
  AST_RD_CNT: assert property (
    s_rd_cnt |-> prdata[7:0] == $past(counter_value))
    else $error("count read not live");
endmodule // etc8_timer_monitor
bind etc8_timer etc8_timer_monitor u_mon (.clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .overflow_pulse, .pwm_duty_data,
  .pwm_resolution_select, .pwm_enable, .counter_value);
`default_nettype wire

// File: sim/tb_eight_bit_timer_event_counter.sv
// Self-checking bench for the 8-bit timer/event counter.
// Assumes design, monitor and pin source compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "etc8_regs.vh"
module tb_eight_bit_timer_event_counter;
  // ---------
  // Harness
  // ---------
  logic        clk, arst_n, psel, penable, pwrite, prescaler_clock, ce, rerr;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, ovf, pwm_clock, pwm_sel, pwm_en, pin;
  wire  [7:0]  duty, cnt;
  int          error_cnt, checks, seed, cyc, m, n;
  etc8_timer u_dut (.clk, .arst_n, .clk_en(ce), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prescaler_clock,
    .timer_input_pin(pin), .irq, .overflow_pulse(ovf), .pwm_clock,
    .pwm_duty_data(duty), .pwm_resolution_select(pwm_sel),
    .pwm_enable(pwm_en), .counter_value(cnt));
  etc8_pin_src u_src (.clk, .pin);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int t;
    t = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t == 50) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      prescaler_clock <= 1'b1;
      @(posedge clk);
      prescaler_clock <= 1'b0;
    end
  endtask
  // Control readback: unused bit reads zero
  function automatic logic [31:0] rb(input logic [7:0] c);
    return {24'h0, c & 8'hdf};
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    seed = 32'h6a1d1098;
    {psel, penable, pwrite, prescaler_clock} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, `ETC8_OFS_CTRL, 0);
    chk("ctrl reset", 0, rdat);
    chk("no slverr", 0, rerr);
    apb(0, 8'h10, 0);
    chk("unmapped", 0, rdat);
    chk("slverr", 1, rerr);
    apb(1, `ETC8_OFS_CTRL, 32'ha0);
    apb(0, `ETC8_OFS_CTRL, 0);
    chk("ctrl", rb(8'ha0), rdat);
    apb(1, 0, 32'hfd);
    tick(4);
    apb(0, 0, 0);
    chk("stopped", 32'hfd, rdat);
    apb(1, `ETC8_OFS_IRQ_MASK, 1);
    apb(1, `ETC8_OFS_CTRL, 32'h90);
    apb(1, 0, 32'h40);
    apb(0, 0, 0);
    chk("running", 32'hfd, rdat);
    tick(3);
    apb(0, 0, 0);
    chk("reload", 32'h40, rdat);
    chk("irq on", 1, irq);
    apb(0, `ETC8_OFS_IRQ_STAT, 0);
    chk("status", 1, rdat);
    @(posedge clk);
    chk("irq off", 0, irq);
    m = 1 + {$random(seed)} % 60;
    tick(m);
    apb(0, 0, 0);
    chk("count", 32'h40 + m, rdat);
    // Ticks while the clock enable is low must be lost
    ce <= 1'b0;
    tick(5);
    ce <= 1'b1;
    apb(0, 0, 0);
    chk("frozen", 32'h40 + m, rdat);
    apb(1, `ETC8_OFS_IRQ_MASK, 0);
    tick(32'hc0 - m);
    repeat (3) @(posedge clk);
    chk("masked", 0, irq);
    apb(0, `ETC8_OFS_IRQ_STAT, 0);
    chk("status", 1, rdat);
    for (int k = 0; k < 8; k++) begin
      apb(1, `ETC8_OFS_CTRL, 32'h80 | k);
      apb(1, 0, 0);
      apb(1, `ETC8_OFS_CTRL, 32'h90 | k);
      m = 1 + {$random(seed)} % 8;
      tick(m << k);
      apb(0, 0, 0);
      chk("prescale", m, rdat);
    end
    // Prescaler ticks run alongside pin events and must not count
    for (int e = 0; e < 2; e++) begin
      apb(1, `ETC8_OFS_CTRL, 32'h40);
      apb(1, 0, 0);
      apb(1, `ETC8_OFS_CTRL, 32'h50 | e * 32'h0f);
      n = 1 + {$random(seed)} % 20;
      fork
        u_src.toggle(2 * n, 1 + {$random(seed)} % 3);
        tick(3 * n);
      join
      apb(0, 0, 0);
      chk("events", n, rdat);
    end
    for (int e = 0; e < 2; e++) begin
      apb(1, `ETC8_OFS_CTRL, 32'hc0 | e << 3);
      apb(1, 0, 0);
      u_src.drive(!e, 2);
      apb(1, `ETC8_OFS_CTRL, 32'hd0 | e << 3);
      m = 1 + {$random(seed)} % 30;
      u_src.drive(e, 2);
      tick(m);
      u_src.drive(!e, 2);
      tick(4);
      apb(0, 0, 0);
      chk("width", m, rdat);
      apb(0, `ETC8_OFS_CTRL, 0);
      chk("auto stop", rb(8'hc0 | e << 3), rdat);
      apb(0, `ETC8_OFS_IRQ_STAT, 0);
      chk("measured", 2, rdat);
    end
    for (int d = 0; d < 7; d++) begin
      apb(1, `ETC8_OFS_CTRL, d << 2 | d & 3);
      n = $random(seed);
      apb(1, 0, n);
      apb(0, 0, 0);
      chk("duty rd", n & 32'hff, rdat);
      chk("duty", n & 32'hff, duty);
      chk("pwm en", d & 1, pwm_en);
      v = cnt;
      m = 0;
      repeat (128) begin
        @(posedge clk);
        m += pwm_clock;
      end
      chk("pwm clock", 128 >> d, m);
      chk("pwm runs", 1, cnt !== v);
    end
    summarize();
  end
endmodule // tb_eight_bit_timer_event_counter
`default_nettype wire

// File: verilog/etc8_regs.vh
// Register map, field positions and reset values of the 8-bit
// timer/event counter. Definitions only; included by bare name.
`ifndef ETC8_REGS_VH
`define ETC8_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------
`define ETC8_OFS_COUNT      8'h00
`define ETC8_OFS_CTRL       8'h04
`define ETC8_OFS_IRQ_STAT   8'h08
`define ETC8_OFS_IRQ_MASK   8'h0c

// ----------------------------------------------------------------
// Control byte fields (timer_control / pwm_control share it)
// ----------------------------------------------------------------
`define ETC8_MODE_HI        7
`define ETC8_MODE_LO        6
`define ETC8_UNUSED_BIT     5
`define ETC8_CEN_BIT        4
`define ETC8_EDGE_BIT       3
`define ETC8_PSC_HI         2
`define ETC8_PSC_LO         0
`define ETC8_DIV_HI         4
`define ETC8_DIV_LO         2
`define ETC8_PSEL_BIT       1
`define ETC8_PEN_BIT        0
`define ETC8_CTRL_WMASK     8'hdf

// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define ETC8_MODE_PWM       2'h0
`define ETC8_MODE_EVENT     2'h1
`define ETC8_MODE_TIMER     2'h2
`define ETC8_MODE_PWIDTH    2'h3

// ----------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------
`define ETC8_IRQ_OVF_BIT    0
`define ETC8_IRQ_PWD_BIT    1
`define ETC8_IRQ_W          2
`define ETC8_RST_COUNT      8'h00
`define ETC8_RST_CTRL       8'h00
`define ETC8_RST_IRQ        2'h0
`define ETC8_COUNT_FULL     8'hff
`define ETC8_PWM_DIV_MAX    3'h6

`endif

// File: verilog/etc8_timer.v
// 8-bit up-counting timer/event counter with preload, four modes,
// APB register access and a masked, read-to-clear overflow and pulse-end interrupt.
// Assumes all inputs synchronous to clk; prescaler_clock is a one-cycle
// tick at the prescaler rate, derived elsewhere from the system clock.
//
// Contract
// - Count by one per selected tick or edge
// - Overflow from full count raises interrupt request
// - Overflow reloads preload and keeps counting
// - Stopped: preload write also loads counter
// - Running: write updates preload only
// - Mode field selects four modes, reset PWM
// - Enable bit starts and stops, counter holds
// - PWM mode ignores the enable bit
// - Internal clock is prescaler divided by power-two
// - External source ignores internal clock select
// - Event mode: edge select picks rise/fall
// - Pulse mode: start/stop edges from edge select
// - Control bit five reads zero, ignores writes
// - PWM registers alias timer register addresses
// - PWM clock is system clock over power-two
// - Counter address reads the live counter, the duty byte in PWM mode
// - Event mode counts only pin transitions
// - Pulse mode clears enable at pulse end
`timescale 1ns/1ps
`default_nettype none
`include "etc8_regs.vh"

module etc8_timer (
  input  wire        clk,              // 25 MHz logic clock
  input  wire        arst_n,           // Async reset, active low
  input  wire        clk_en,           // Freezes all state when low
  input  wire        psel,             // APB select
  input  wire        penable,          // APB access phase
  input  wire        pwrite,           // APB write
  input  wire [7:0]  paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output reg  [31:0] prdata,           // APB read data
  output wire        pready,           // APB ready
  output wire        pslverr,          // APB error, unmapped address
  input  wire        prescaler_clock,  // Prescaler tick
  input  wire        timer_input_pin,  // External event/pulse pin
  output wire        irq,              // Level interrupt
  output reg         overflow_pulse,   // One-cycle overflow request
  output reg         pwm_clock,        // One-cycle tick at pwm rate
  output reg  [7:0]  pwm_duty_data,    // Duty for PWM generator
  output wire        pwm_resolution_select, // 0: 6+2, 1: 7+1
  output wire        pwm_enable,       // PWM generator enable
  output reg  [7:0]  counter_value     // Live counter
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam PW_WAIT = 1'b0;
  localparam PW_MEAS = 1'b1;

  reg  [7:0]  preload;
  reg  [7:0]  ctrl;
  reg  [`ETC8_IRQ_W-1:0] irq_stat;
  reg  [`ETC8_IRQ_W-1:0] irq_mask;
  reg  [`ETC8_IRQ_W-1:0] rd_seen;
  reg  [6:0]  psc_cnt;
  reg  [5:0]  div_cnt;
  reg         pin_prev;
  reg         pin_primed;
  reg         pw_state;

  reg  [7:0]  next_counter;
  reg  [7:0]  next_preload;
  reg  [7:0]  next_ctrl;
  reg         next_pw_state;
  reg         ovf_evt;
  reg         pwd_evt;
  reg         inc;
  reg  [7:0]  rd_word;
  reg  [6:0]  psc_mask;
  reg  [5:0]  div_mask;
  reg  [2:0]  div_sel;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [1:0] mode_select      = ctrl[`ETC8_MODE_HI:`ETC8_MODE_LO];
  wire       count_enable     = ctrl[`ETC8_CEN_BIT];
  wire       edge_select      = ctrl[`ETC8_EDGE_BIT];
  wire [2:0] internal_clock_select = ctrl[`ETC8_PSC_HI:`ETC8_PSC_LO];
  wire [2:0] pwm_clock_divider = ctrl[`ETC8_DIV_HI:`ETC8_DIV_LO];

  wire mode_pwm   = (mode_select == `ETC8_MODE_PWM);
  wire mode_event = (mode_select == `ETC8_MODE_EVENT);
  wire mode_timer = (mode_select == `ETC8_MODE_TIMER);
  wire mode_pw    = (mode_select == `ETC8_MODE_PWIDTH);

  assign pwm_resolution_select = ctrl[`ETC8_PSEL_BIT];
  assign pwm_enable            = mode_pwm & ctrl[`ETC8_PEN_BIT];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states; a low clock enable stretches the access.
  assign pready = clk_en;

  wire hit_count = (paddr == `ETC8_OFS_COUNT);
  wire hit_ctrl  = (paddr == `ETC8_OFS_CTRL);
  wire hit_stat  = (paddr == `ETC8_OFS_IRQ_STAT);
  wire hit_mask  = (paddr == `ETC8_OFS_IRQ_MASK);
  wire hit_any   = hit_count | hit_ctrl | hit_stat | hit_mask;

  assign pslverr = psel & penable & ~hit_any;

  wire setup_rd = clk_en & psel & ~penable & ~pwrite;
  wire acc      = clk_en & psel & penable;
  wire wr_ok    = acc & pwrite & hit_any;
  wire rd_done  = acc & ~pwrite;

  wire wr_count = wr_ok & hit_count;
  wire wr_ctrl  = wr_ok & hit_ctrl;
  wire wr_mask  = wr_ok & hit_mask;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_word = 8'h00;
    if (hit_count) begin
      if (mode_pwm) begin
        rd_word = pwm_duty_data;
      end else begin
        rd_word = counter_value;
      end
    end else if (hit_ctrl) begin
      rd_word = ctrl;
    end else if (hit_stat) begin
      rd_word = {6'h00, irq_stat};
    end else if (hit_mask) begin
      rd_word = {6'h00, irq_mask};
    end
  end

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  always @* begin
    psc_mask = 7'h00;
    case (internal_clock_select)
      3'h0: psc_mask = 7'h00;
      3'h1: psc_mask = 7'h01;
      3'h2: psc_mask = 7'h03;
      3'h3: psc_mask = 7'h07;
      3'h4: psc_mask = 7'h0f;
      3'h5: psc_mask = 7'h1f;
      3'h6: psc_mask = 7'h3f;
      3'h7: psc_mask = 7'h7f;
      default: psc_mask = 7'h00;
    endcase
  end

  // Divide by 2^n: one tick out of every 2^n prescaler ticks
  wire int_tick = prescaler_clock &
                  ((psc_cnt & psc_mask) == psc_mask);

  // Codes above the top divider saturate at /64
  always @* begin
    div_sel = pwm_clock_divider;
    if (pwm_clock_divider > `ETC8_PWM_DIV_MAX) begin
      div_sel = `ETC8_PWM_DIV_MAX;
    end
    div_mask = 6'h00;
    case (div_sel)
      3'h0: div_mask = 6'h00;
      3'h1: div_mask = 6'h01;
      3'h2: div_mask = 6'h03;
      3'h3: div_mask = 6'h07;
      3'h4: div_mask = 6'h0f;
      3'h5: div_mask = 6'h1f;
      default: div_mask = 6'h3f;
    endcase
  end

  wire pwm_tick = ((div_cnt & div_mask) == div_mask);

  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  // No edge is reported until one pin sample has been taken after reset.
  wire pin_rise = pin_primed & timer_input_pin & ~pin_prev;
  wire pin_fall = pin_primed & ~timer_input_pin & pin_prev;

  wire ev_edge    = edge_select ? pin_fall : pin_rise;
  wire pw_start   = edge_select ? pin_rise : pin_fall;
  wire pw_stop    = edge_select ? pin_fall : pin_rise;

  // ----------------------------------------------------------------
  // Counter, preload, control and pulse-width sequencing
  // ----------------------------------------------------------------
  wire running = ~mode_pwm & count_enable;

  always @* begin
    next_counter  = counter_value;
    next_preload  = preload;
    next_ctrl     = ctrl;
    next_pw_state = pw_state;
    ovf_evt       = 1'b0;
    pwd_evt       = 1'b0;
    inc           = 1'b0;

    // Pulse width: armed by enable, measures between two edges
    case (pw_state)
      PW_WAIT: begin
        if (mode_pw && count_enable && pw_start) begin
          next_pw_state = PW_MEAS;
        end
      end
      PW_MEAS: begin
        if (!mode_pw || !count_enable) begin
          next_pw_state = PW_WAIT;
        end else if (pw_stop) begin
          next_pw_state = PW_WAIT;
          next_ctrl[`ETC8_CEN_BIT] = 1'b0;
          pwd_evt = 1'b1;
        end
      end
      default: next_pw_state = PW_WAIT;
    endcase

    // Count source per mode
    case (mode_select)
      `ETC8_MODE_PWM:    inc = pwm_tick;
      `ETC8_MODE_EVENT:  inc = running & ev_edge;
      `ETC8_MODE_TIMER:  inc = running & int_tick;
      `ETC8_MODE_PWIDTH: inc = running & (pw_state == PW_MEAS) &
                               ~pw_stop & int_tick;
      default:           inc = 1'b0;
    endcase

    // Writes to the shared count address
    if (wr_count && !mode_pwm) begin
      next_preload = pwdata[7:0];
      if (!running) begin
        next_counter = pwdata[7:0];
      end
    end

    if (inc) begin
      if (counter_value == `ETC8_COUNT_FULL) begin
        next_counter = next_preload;
        ovf_evt      = 1'b1;
      end else begin
        next_counter = counter_value + 8'h01;
      end
    end

    // Software write wins over the automatic enable clear
    if (wr_ctrl) begin
      next_ctrl = pwdata[7:0] & `ETC8_CTRL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_value  <= `ETC8_RST_COUNT;
      preload        <= `ETC8_RST_COUNT;
      pwm_duty_data  <= `ETC8_RST_COUNT;
      ctrl           <= `ETC8_RST_CTRL;
      pw_state       <= PW_WAIT;
      psc_cnt        <= 7'h00;
      div_cnt        <= 6'h00;
      pin_prev       <= 1'b0;
      pin_primed     <= 1'b0;
      overflow_pulse <= 1'b0;
      pwm_clock      <= 1'b0;
    end else if (clk_en) begin
      counter_value  <= next_counter;
      preload        <= next_preload;
      ctrl           <= next_ctrl;
      pw_state       <= next_pw_state;
      pin_prev       <= timer_input_pin;
      pin_primed     <= 1'b1;
      overflow_pulse <= ovf_evt;
      pwm_clock      <= pwm_tick;
      div_cnt        <= div_cnt + 6'h01;
      if (prescaler_clock) begin
        psc_cnt <= psc_cnt + 7'h01;
      end
      if (wr_count && mode_pwm) begin
        pwm_duty_data <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and read data
  // ----------------------------------------------------------------
  // A read clears only the bits it returned; a new event the same
  // cycle survives the clear.
  wire [`ETC8_IRQ_W-1:0] irq_set = {pwd_evt, ovf_evt};
  wire [`ETC8_IRQ_W-1:0] irq_clr =
    (rd_done & hit_stat) ? rd_seen : {`ETC8_IRQ_W{1'b0}};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= `ETC8_RST_IRQ;
      irq_mask <= `ETC8_RST_IRQ;
      rd_seen  <= `ETC8_RST_IRQ;
      prdata   <= 32'h00000000;
    end else if (clk_en) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_mask) begin
        irq_mask <= pwdata[`ETC8_IRQ_W-1:0];
      end
      if (setup_rd) begin
        prdata  <= {24'h000000, rd_word};
        rd_seen <= irq_stat;
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule // etc8_timer

`default_nettype wire
